// File: floppy_if_pkg.sv
// shared constants, types and carriers of the floppy host interface
package floppy_if_pkg;

	localparam int WORD_W        = 12;     // host accumulator width
	localparam int BYTE_W        = 8;      // word width in 8-bit mode
	localparam int FIFO_DEPTH    = 8;      // words held between host and sector buffer
	localparam int FILL_WORDS_12 = 64;     // fill length in 12-bit mode
	localparam int FILL_WORDS_8  = 128;    // fill length in 8-bit mode
	localparam int TRACK_COUNT   = 77;     // tracks 0 .. 76
	localparam int SECTOR_COUNT  = 26;     // sectors 1 .. 26
	localparam int CNT_W         = 8;      // fill word counters

	// accumulator fields, lsb numbering (the host calls bit 0 the msb)
	localparam int AC_MAINT   = 7;         // host bit 4
	localparam int AC_MODE    = 6;         // host bit 5, 1 = 8-bit
	localparam int AC_DRIVE   = 4;         // host bit 7
	localparam int AC_FUNC_LO = 1;         // host bits 8..10
	localparam int AC_IE      = 0;         // host bit 11

	// error and status word fields, lsb numbering
	localparam int ST_CRC   = 0;           // host bit 11
	localparam int ST_PAR   = 1;           // host bit 10
	localparam int ST_INIT  = 2;           // host bit 9
	localparam int ST_DD    = 6;           // host bit 5
	localparam int ST_READY = 7;           // host bit 4

	localparam logic [11:0] RESET_WORD = 12'h000;   // interface register after reset

	// io transfer instruction codes, in their printed order
	typedef enum logic [2:0] {
		IOT_NOP, IOT_LCD, IOT_XDR, IOT_STR, IOT_SER, IOT_SDN, IOT_INTERRUPT_ENABLE_INSTR, IOT_INIT
	} iot_t;

	// function codes carried in the command word
	typedef enum logic [2:0] {
		FN_FILL, FN_EMPTY, FN_WRITE, FN_READ, FN_UNUSED, FN_STATUS, FN_WDEL, FN_RDERR
	} func_t;

	// what the interface register receives when a function ends
	typedef enum logic [1:0] {
		FIN_PLAIN, FIN_STATUS, FIN_ERRCODE, FIN_INIT
	} fin_kind_t;

	// one instruction from the host
	typedef struct packed {
		logic        strobe;               // one-cycle instruction pulse
		iot_t        op;                   // instruction code
		logic [11:0] ac;                   // accumulator during the instruction
	} io_req_t;

	// answer to the host
	typedef struct packed {
		logic        acc_write;            // load acc into the accumulator
		logic        skip;                 // skip the next instruction
		logic [11:0] acc;                  // new accumulator value
	} io_ans_t;

	// request to the disk mechanics
	typedef struct packed {
		logic       start;                 // one-cycle start pulse
		logic       init;                  // initialize sequence
		logic       write;                 // write (else read)
		logic       deleted;               // write a deleted data mark
		logic       drive;                 // selected drive
		logic [7:0] track;                 // track address
		logic [7:0] sector;                // sector address
	} disk_cmd_t;

	// sticky status bits
	typedef struct packed {
		logic dd;                          // deleted data
		logic init_done;                   // initialize completed
		logic par;                         // link parity error
		logic crc;                         // check sequence error
	} stat_t;

endpackage

// File: word_fifo.sv
// synchronous word fifo with valid and ready on both sides
`timescale 1ns/100ps
module word_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];         // word storage
	logic [PTR_W-1:0] wr_ptr;              // next slot to write
	logic [PTR_W-1:0] rd_ptr;              // oldest slot
	logic [CNT_W-1:0] count;               // words held
	wire              push;                // word enters
	wire              pop;                 // word leaves

	assign in_ready  = count != CNT_W'(DEPTH);
	assign out_valid = count != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	////////////////////////////////////////////////////////////////////////////////
	// storage writes
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers wrap at depth, count tracks both sides
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + CNT_W'(push) - CNT_W'(pop);
		end
	end
endmodule

// File: floppy_host_interface_register_logic.sv
// host interface register, flags and function sequencing of the floppy subsystem
//
// Overview of operation
// RULE1: load command with bit 4 sets maintenance
// RULE2: maintenance blocks run, transfers go to accumulator
// RULE3: initialize or load with bit 4 clear
// RULE4: maintenance loads write interface register for readback
// RULE5: maintenance forces skip flags, skips keep them
// RULE6: done and enable raise interrupt request
// RULE7: initialize clears skip flags and interrupt enable
// RULE8: addresses taken only at their step, high nibble ignored
// RULE9: command bit 5 fixes transfer width
// RULE10: status word loaded at end of each function; read error register loads error_code instead
// RULE11: check sequence failure sets status bit 11
// RULE12: link parity error ends function with error
// RULE13: bit 9 marks initialize, hidden from read status
// RULE14: deleted mark or deleted write sets bit 5
// RULE15: bit 4 shows drive ready, status or initialize
// RULE16: host clears done before loading a command
// RULE17: load command in done state leaves done
// RULE18: function from bits 8 to 10 only
// RULE19: fill loads exactly 64 or 128 words
// RULE20: fill raises transfer request for every word
// RULE21: host clears transfer request before each transfer
// RULE22: done only after the final fill word
// RULE23: transfers after done return the status word
// RULE24: bit 7 drive, bit 5 mode, start 12-bit
// RULE25: 8-bit reads or into low byte
// RULE26: interrupt request is a level
`timescale 1ns/100ps
module floppy_host_interface_register_logic
	import floppy_if_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic                    clock,
	input  wire logic                    srst,
	input  wire logic                    bus_init,
	input  wire floppy_if_pkg::io_req_t  io_req,
	output floppy_if_pkg::io_ans_t       io_ans,
	output logic                         irq,
	output logic                         run_strobe,
	output logic       [11:0]            fill_data,
	output logic                         fill_valid,
	input  wire logic                    fill_ready,
	output logic                         fill_byte_mode,
	output floppy_if_pkg::disk_cmd_t     disk_cmd,
	input  wire logic                    disk_done,
	input  wire logic                    disk_seek_error,
	input  wire logic                    disk_crc_error,
	input  wire logic                    disk_deleted_mark,
	input  wire logic                    link_parity_error,
	input  wire logic  [1:0]             drive_ready,
	input  wire logic  [11:0]            error_code
);
	import floppy_if_pkg::*;

	typedef enum {
		ST_IDLE, ST_FILL, ST_PUSH, ST_DRAIN, ST_SECT, ST_TRACK, ST_DISK, ST_FIN
	} state_t;

	// true when the host issues the given instruction this cycle
	function automatic logic iot_is(io_req_t r, iot_t op);
		return r.strobe && (r.op == op);
	endfunction

	// error and status word built from sticky bits
	function automatic logic [11:0] status_word(stat_t s, logic rdy, logic with_init);
		logic [11:0] w;
		w = '0;
		w[ST_CRC]   = s.crc;
		w[ST_PAR]   = s.par;
		w[ST_INIT]  = s.init_done && with_init;
		w[ST_DD]    = s.dd;
		w[ST_READY] = rdy;
		return w;
	endfunction

	state_t          state;                // function sequencer
	logic            maint;                // maintenance flip-flop
	logic            tr;                   // transfer request flag
	logic            err;                  // error flag
	logic            done;                 // done flag
	logic            ie;                   // interrupt enable
	logic            byte_mode;            // 1 = 8-bit transfers
	logic            drive;                // selected drive
	func_t           func;                 // function in progress
	logic [11:0]     iface;                // the interface register
	stat_t           stat;                 // sticky status bits
	fin_kind_t       fin_kind;             // word loaded at completion
	logic            fin_err;              // completion raises error
	logic [CNT_W-1:0] fill_count;          // words pushed into the fifo
	logic [CNT_W-1:0] drain_count;         // words taken by the sector buffer
	logic [7:0]      track;                // track address
	logic [7:0]      sector;               // sector address

	////////////////////////////////////////////////////////////////////////////////
	// instruction decoding
	wire       is_lcd   = iot_is(io_req, IOT_LCD);
	wire       is_xdr   = iot_is(io_req, IOT_XDR);
	wire       is_str   = iot_is(io_req, IOT_STR);
	wire       is_ser   = iot_is(io_req, IOT_SER);
	wire       is_sdn   = iot_is(io_req, IOT_SDN);
	wire       is_interrupt_enable_instr  = iot_is(io_req, IOT_INTERRUPT_ENABLE_INSTR);
	wire       do_init  = iot_is(io_req, IOT_INIT) || bus_init;
	wire func_t new_func = func_t'(io_req.ac[AC_FUNC_LO +: 3]);          // see RULE18
	wire [7:0] ac_lo    = io_req.ac[7:0];                                // see RULE8
	wire       cmd_go   = is_lcd && !maint && !io_req.ac[AC_MAINT] && state == ST_IDLE;
	wire       to_dev   = state == ST_FILL || state == ST_SECT || state == ST_TRACK;
	wire       xdr_in   = is_xdr && !maint && to_dev;                    // see RULE2
	wire       xdr_out  = is_xdr && !xdr_in;                             // see RULE23
	wire       rw_func  = new_func == FN_WRITE || new_func == FN_READ || new_func == FN_WDEL;
	wire [CNT_W-1:0] fill_total = byte_mode ? CNT_W'(FILL_WORDS_8)
	                                        : CNT_W'(FILL_WORDS_12); // see RULE19
	wire       fifo_in_ready;
	wire       push_ok  = state == ST_PUSH && fifo_in_ready;
	wire       push_last = fill_count == fill_total - 1'b1;
	wire       sect_ok  = state == ST_SECT && xdr_in && !link_parity_error;
	wire       track_bad = ac_lo >= 8'(TRACK_COUNT);
	wire       fin_now  = state == ST_FIN;
	wire       set_tr   = (cmd_go && (new_func == FN_FILL || (rw_func && !link_parity_error)))
	                   || (push_ok && !push_last) || sect_ok;               // see RULE20
	wire [11:0] fin_word =
		(fin_kind == FIN_ERRCODE) ? error_code :
		(fin_kind == FIN_STATUS)  ? status_word(stat, drive_ready[drive], 1'b0) : // see RULE13
		(fin_kind == FIN_INIT)    ? status_word(stat, drive_ready[0], 1'b1) :     // see RULE15
		status_word(stat, 1'b0, 1'b1);
	wire [11:0] acc_read = byte_mode ? {io_req.ac[11:8], io_req.ac[7:0] | iface[7:0]}
	                                 : iface;                             // see RULE25
	wire       skip_hit = (is_str && tr) || (is_ser && err) || (is_sdn && done);

	assign irq            = done && ie;                                   // see RULE6 RULE26
	assign fill_byte_mode = byte_mode;                                    // see RULE9

	////////////////////////////////////////////////////////////////////////////////
	// maintenance flip-flop
	always_ff @(posedge clock) begin
		if (srst || do_init) begin
			maint <= 1'b0;                                                // see RULE3
		end else if (is_lcd) begin
			maint <= io_req.ac[AC_MAINT];                                 // see RULE1 RULE3
		end
	end

	// skip flags: init clears, maintenance forces, set wins over a skip
	always_ff @(posedge clock) begin
		if (srst || do_init) begin
			tr   <= 1'b0;                                                 // see RULE7
			err  <= 1'b0;
			done <= 1'b0;
		end else if (maint) begin
			tr   <= 1'b1;                                                 // see RULE5
			err  <= 1'b1;
			done <= 1'b1;
		end else begin
			tr   <= set_tr || (tr && !is_str);
			err  <= (fin_now && fin_err) || (err && !is_ser);
			done <= fin_now || (done && !is_sdn && !cmd_go);              // see RULE17 RULE22
		end
	end

	// interrupt enable
	always_ff @(posedge clock) begin
		if (srst || do_init) begin
			ie <= 1'b0;                                                   // see RULE7
		end else if (is_interrupt_enable_instr) begin
			ie <= io_req.ac[AC_IE];                                       // see RULE6
		end
	end

	// command fields captured when a function starts
	always_ff @(posedge clock) begin
		if (srst || do_init) begin
			byte_mode <= 1'b0;                                            // see RULE24
			drive     <= 1'b0;
			func      <= FN_FILL;
		end else if (cmd_go) begin
			byte_mode <= io_req.ac[AC_MODE];                              // see RULE9 RULE24
			drive     <= io_req.ac[AC_DRIVE];                             // see RULE24
			func      <= new_func;
		end
	end

	// interface register: command, host words, completion word
	always_ff @(posedge clock) begin
		if (srst) begin
			iface <= RESET_WORD;
		end else if (is_lcd || xdr_in) begin
			iface <= io_req.ac;                                           // see RULE4
		end else if (fin_now) begin
			iface <= fin_word;                                            // see RULE10
		end
	end

	// answers to the host and the run strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			io_ans     <= '0;
			run_strobe <= 1'b0;
		end else begin
			io_ans.acc_write <= is_lcd || xdr_out;
			io_ans.acc       <= is_lcd ? '0 : acc_read;                   // see RULE23
			io_ans.skip      <= skip_hit;
			run_strobe       <= xdr_in;                                   // see RULE2
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// function sequencer
	always_ff @(posedge clock) begin
		disk_cmd.start <= 1'b0;
		if (srst) begin
			state    <= ST_IDLE;
			stat     <= '0;
			fin_kind <= FIN_PLAIN;
			fin_err  <= 1'b0;
			disk_cmd <= '0;
			track    <= '0;
			sector   <= '0;
		end else if (do_init) begin
			stat           <= '0;                                         // status zeroed
			fin_err        <= 1'b0;                                       // no stale error after init
			state          <= ST_DISK;
			disk_cmd.init  <= 1'b1;
			disk_cmd.start <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_go) begin
						fin_kind <= FIN_PLAIN;
						fin_err  <= 1'b0;
						if (rw_func) begin
							stat.par <= 1'b0;
							stat.crc <= 1'b0;
							if (new_func == FN_READ) begin
								stat.dd <= 1'b0;
							end
						end
						if (link_parity_error) begin
							stat.par <= 1'b1;                             // see RULE12
							fin_err  <= 1'b1;
							state    <= ST_FIN;
						end else begin
							case (new_func)
								FN_FILL:   state <= ST_FILL;
								FN_WRITE,
								FN_READ,
								FN_WDEL:   state <= ST_SECT;
								FN_STATUS: begin
									fin_kind <= FIN_STATUS;
									state    <= ST_FIN;
								end
								FN_RDERR: begin
									fin_kind <= FIN_ERRCODE;
									state    <= ST_FIN;
								end
								default:   state <= ST_FIN;
							endcase
						end
					end
				end
				ST_FILL: begin
					if (xdr_in) begin
						state <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					if (push_ok) begin
						state <= push_last ? ST_DRAIN : ST_FILL;
					end
				end
				ST_DRAIN: begin
					if (drain_count == fill_total) begin
						state <= ST_FIN;                                  // see RULE22
					end
				end
				ST_SECT: begin
					if (xdr_in) begin
						sector <= ac_lo;                                  // see RULE8
						if (link_parity_error) begin
							stat.par <= 1'b1;                             // see RULE12
							fin_err  <= 1'b1;
							state    <= ST_FIN;
						end else begin
							state <= ST_TRACK;
						end
					end
				end
				ST_TRACK: begin
					if (xdr_in) begin
						track <= ac_lo;                                   // see RULE8
						if (link_parity_error) begin
							stat.par <= 1'b1;                             // see RULE12
						end
						if (link_parity_error || track_bad) begin
							fin_err <= 1'b1;
							state   <= ST_FIN;
						end else begin
							disk_cmd.start   <= 1'b1;
							disk_cmd.init    <= 1'b0;
							disk_cmd.write   <= func != FN_READ;
							disk_cmd.deleted <= func == FN_WDEL;
							disk_cmd.drive   <= drive;
							disk_cmd.track   <= ac_lo;
							disk_cmd.sector  <= sector;
							state            <= ST_DISK;
						end
					end
				end
				ST_DISK: begin
					if (disk_done) begin
						state <= ST_FIN;
						if (disk_cmd.init) begin
							stat.init_done <= 1'b1;                       // see RULE13
							fin_kind       <= FIN_INIT;
							disk_cmd.init  <= 1'b0;
						end else begin
							stat.crc <= disk_crc_error;                   // see RULE11
							stat.dd  <= disk_cmd.deleted
							         || (!disk_cmd.write && disk_deleted_mark); // see RULE14
							fin_err  <= disk_crc_error || disk_seek_error;
						end
					end
				end
				ST_FIN: begin
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// fill word counters
	always_ff @(posedge clock) begin
		if (srst || cmd_go) begin
			fill_count  <= '0;
			drain_count <= '0;
		end else begin
			if (push_ok) begin
				fill_count <= fill_count + 1'b1;                          // see RULE19
			end
			if (fill_valid && fill_ready) begin
				drain_count <= drain_count + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fifo between host words and the sector buffer
	word_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH)
	) fill_fifo (
		.clock     (clock),
		.srst      (srst),
		.in_valid  (state == ST_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (iface),
		.out_valid (fill_valid),
		.out_ready (fill_ready),
		.out_data  (fill_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_maint_load;
		maint && is_lcd && !do_init;
	endsequence
	sequence s_readback;
		s_maint_load ##1 (!is_lcd && !fin_now) ##1 (maint && is_xdr && !byte_mode);
	endsequence

	property p_maint_set;
		is_lcd && io_req.ac[AC_MAINT] && !do_init |=> maint;
	endproperty
	a_maint_set: assert property (p_maint_set) else $error("maint not set"); // see RULE1

	property p_no_run;
		maint && is_xdr |=> !run_strobe && io_ans.acc_write;
	endproperty
	a_no_run: assert property (p_no_run) else $error("run in maint"); // see RULE2

	property p_maint_clr;
		(is_lcd && !io_req.ac[AC_MAINT]) || do_init |=> !maint;
	endproperty
	a_maint_clr: assert property (p_maint_clr) else $error("maint stuck"); // see RULE3

	property p_readback;
		s_readback |=> io_ans.acc == $past(io_req.ac, 3);
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong"); // see RULE4

	property p_forced;
		maint && !do_init |=> tr && err && done;
	endproperty
	a_forced: assert property (p_forced) else $error("flags not forced"); // see RULE5

	property p_irq;
		is_interrupt_enable_instr && io_req.ac[AC_IE] && !do_init ##1 done |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing"); // see RULE6

	property p_init;
		do_init |=> !tr && !err && !done && !ie && !maint;
	endproperty
	a_init: assert property (p_init) else $error("init left flags"); // see RULE7

	property p_notdone;
		cmd_go && !do_init |=> !done;
	endproperty
	a_notdone: assert property (p_notdone) else $error("done kept"); // see RULE17

	property p_fill_tr;
		push_ok && !push_last && !do_init |=> tr;
	endproperty
	a_fill_tr: assert property (p_fill_tr) else $error("no next request"); // see RULE20

	property p_status_out;
		done && is_xdr && !maint && state == ST_IDLE && !byte_mode |=> io_ans.acc == $past(iface);
	endproperty
	a_status_out: assert property (p_status_out) else $error("status not returned"); // see RULE23
endmodule

// File: far_side_model.sv
// far-side model: sector buffer sink with stalls, and disk mechanics
`timescale 1ns/100ps
module far_side_model (
	input  wire logic                     clock,
	input  wire logic                     fill_valid,
	output logic                          fill_ready,
	input  wire floppy_if_pkg::disk_cmd_t disk_cmd,
	output logic                          disk_done,
	output int                            n_words
);
	import floppy_if_pkg::*;
	logic [2:0] pace = 3'h0;  // stall pattern counter
	logic [3:0] busy = 4'h0;  // disk operation countdown
	initial begin
		fill_ready = 1'b0;
		disk_done = 1'b0;
		n_words = 0;
	end
	////////////////////////////////////////////////////////////
	// buffer takes words on three cycles of eight, so the fifo backs up
	always @(posedge clock) begin
		pace <= pace + 3'h1;
		fill_ready <= (pace < 3'h3);
		if (fill_valid && fill_ready) n_words <= n_words + 1;
	end
	// disk answers every start after a slow fixed delay
	always @(posedge clock) begin
		if (disk_cmd.start) busy <= 4'hf;
		else if (busy != 4'h0) busy <= busy - 4'h1;
		disk_done <= (busy == 4'h1);
	end
endmodule

// File: test_floppy_host_interface_register_logic.sv
// self-checking bench of the floppy host interface logic
`timescale 1ns/100ps
module test_floppy_host_interface_register_logic;
	import floppy_if_pkg::*;
	logic        clock = 0;           // bench clock
	logic        srst = 1;            // synchronous reset
	logic        bus_init = 0;        // bus initialize
	io_req_t     io_req = '0;         // host instruction
	io_ans_t     io_ans;              // host answer
	logic        irq, run_strobe, fill_valid, fill_ready, fill_byte_mode, disk_done;
	logic [11:0] fill_data;           // word toward sector buffer
	disk_cmd_t   disk_cmd;            // request to disk
	logic [1:0]  drive_ready = 2'h1;  // drive ready levels
	logic [13:0] notes[$];            // {check, is skip, value} per instruction
	logic [13:0] nt;                  // note under comparison
	logic        taken = 0;           // instruction taken at last edge
	logic        got_skip;            // skip seen by last instruction
	logic [31:0] seed = 32'h33e7301d; // random source
	logic [11:0] fill_exp[$];         // words due at the sector buffer
	logic        flt = 0, par_err = 0; // injected disk and link faults
	int          n_errors = 0, tests_run = 0, n_runs = 0, n_words, cycles = 0;
	always #2 clock = ~clock;
	floppy_host_interface_register_logic floppy_host_interface_register_logic_i (
		.clock(clock), .srst(srst), .bus_init(bus_init), .io_req(io_req), .io_ans(io_ans),
		.irq(irq), .run_strobe(run_strobe), .fill_data(fill_data), .fill_valid(fill_valid),
		.fill_ready(fill_ready), .fill_byte_mode(fill_byte_mode), .disk_cmd(disk_cmd),
		.disk_done(disk_done), .disk_seek_error(1'b0), .disk_crc_error(flt),
		.disk_deleted_mark(flt), .link_parity_error(par_err), .drive_ready(drive_ready),
		.error_code(seed[11:0]));
	far_side_model far_side_model_i (.clock(clock), .fill_valid(fill_valid),
		.fill_ready(fill_ready), .disk_cmd(disk_cmd), .disk_done(disk_done),
		.n_words(n_words));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// notes: expected skip, expected accumulator
	function automatic logic [13:0] sk(input logic e);
		return {2'h3, 11'h000, e};
	endfunction
	function automatic logic [13:0] acn(input logic [11:0] v);
		return {2'h2, v};
	endfunction
	task automatic check(input logic [12:0] got, input logic [12:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one instruction: strobe for one cycle, answer seen at next falling edge
	task automatic io_transfer_instr(input iot_t op, input logic [11:0] ac, input logic [13:0] note);
		@(negedge clock);
		notes.push_back(note);
		io_req <= '{1'b1, op, ac};
		@(negedge clock);
		io_req.strobe <= 1'b0;
		got_skip = io_ans.skip;
	endtask
	// poll a flag with its skip instruction, bounded
	task automatic wait_flag(input iot_t op);
		got_skip = 1'b0;
		for (int i = 0; i < 300 && got_skip !== 1'b1; i++) io_transfer_instr(op, 12'h000, 14'h0);
	endtask
	////////////////////////////////////////////////////////////
	// watcher: oldest note against the answer
	always @(posedge clock) taken <= io_req.strobe;
	always @(posedge clock) if (run_strobe) n_runs++;
	always @(negedge clock) if (taken && notes.size() > 0) begin
		nt = notes.pop_front();
		if (nt[13] && nt[12]) check({12'h000, io_ans.skip}, {12'h000, nt[0]});
		else if (nt[13]) check({io_ans.acc_write, io_ans.acc}, {1'b1, nt[11:0]});
	end
	// every word handed to the sector buffer against what the host sent
	always @(posedge clock) if (fill_valid && fill_ready)
		check({1'b0, fill_data}, {1'b0, fill_exp.pop_front()});
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge clock);
		srst <= 1'b0;
		drive_ready <= seed[1:0];
		io_transfer_instr(IOT_LCD, 12'h080, acn(12'h000));
		io_transfer_instr(IOT_LCD, 12'h9a5, acn(12'h000));
		io_transfer_instr(IOT_XDR, 12'h000, acn(12'h9a5));
		for (int j = 0; j < 6; j++) io_transfer_instr(iot_t'(3 + j % 3), 12'h000, sk(1'b1));
		io_transfer_instr(IOT_INTERRUPT_ENABLE_INSTR, 12'h001, 14'h0);
		check({12'h000, irq}, 13'h001);
		io_transfer_instr(IOT_LCD, 12'h000, acn(12'h000));
		io_transfer_instr(IOT_SER, 12'h000, sk(1'b1));
		io_transfer_instr(IOT_SER, 12'h000, sk(1'b0));
		check(13'(n_runs), 13'h000);
		io_transfer_instr(IOT_INIT, 12'h000, 14'h0);
		check({12'h000, irq}, 13'h000);
		io_transfer_instr(IOT_STR, 12'h000, sk(1'b0));
		$display("test maintenance finished");
		wait_flag(IOT_SDN);
		io_transfer_instr(IOT_XDR, 12'h000, acn({4'h0, drive_ready[0], 7'h04}));
		io_transfer_instr(IOT_LCD, 12'h00b, acn(12'h000));
		wait_flag(IOT_SDN);
		io_transfer_instr(IOT_XDR, 12'h000, acn({4'h0, drive_ready[0], 7'h00}));
		$display("test status finished");
		io_transfer_instr(IOT_LCD, 12'h000, acn(12'h000));
		for (int k = 0; k < 64; k++) begin
			wait_flag(IOT_STR);
			fill_exp.push_back(seed[11:0]);
			io_transfer_instr(IOT_XDR, seed[11:0], 14'h0);
			seed = lfsr(seed);
			if (k == 62) io_transfer_instr(IOT_SDN, 12'h000, sk(1'b0));
		end
		wait_flag(IOT_SDN);
		check(13'(n_words), 13'd64);
		check(13'(n_runs), 13'd64);
		$display("test fill finished");
		par_err <= 1'b1;
		io_transfer_instr(IOT_LCD, 12'h006, acn(12'h000));
		par_err <= 1'b0;
		wait_flag(IOT_SDN);
		io_transfer_instr(IOT_SER, 12'h000, sk(1'b1));
		io_transfer_instr(IOT_XDR, 12'h000, acn(12'h006));
		flt <= 1'b1;
		io_transfer_instr(IOT_LCD, 12'h006, acn(12'h000));
		wait_flag(IOT_STR);
		io_transfer_instr(IOT_XDR, 12'h001, 14'h0);
		wait_flag(IOT_STR);
		io_transfer_instr(IOT_XDR, 12'hf4c, 14'h0);
		wait_flag(IOT_SDN);
		flt <= 1'b0;
		check({5'h00, disk_cmd.track}, 13'h04c);
		io_transfer_instr(IOT_SER, 12'h000, sk(1'b1));
		io_transfer_instr(IOT_XDR, 12'h000, acn(12'h045));
		io_transfer_instr(IOT_LCD, 12'h00e, acn(12'h000));
		wait_flag(IOT_SDN);
		io_transfer_instr(IOT_XDR, 12'h000, acn(seed[11:0]));
		$display("test errors finished");
		io_transfer_instr(IOT_LCD, 12'h04a, acn(12'h000));
		wait_flag(IOT_SDN);
		check({12'h000, fill_byte_mode}, 13'h001);
		io_transfer_instr(IOT_XDR, 12'hf01, acn({4'hf, drive_ready[0], 7'h41}));
		$display("test byte mode finished");
		finish_test();
	end
endmodule
